// >>> src/level_priority_interrupt_controller.sv
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
module level_priority_interrupt_controller #(
    parameter int NUM_SRC = lpic_pkg::NUM_SRC,
    parameter int EV_W = lpic_pkg::EV_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Internal source events, source i at bits i*EV_W
    input wire logic [NUM_SRC*EV_W-1:0] src_events_i,
    // External request pins: [2]=level7/enc2, [1]=level6/enc1, [0]=level1/enc0
    input wire logic [2:0] request_pins_n_i,
    // Core side
    output logic [2:0] core_level_o,
    output logic internal_pending_indication_o,
    output logic bus_clear_request_o,
    // Acknowledge cycle
    input wire logic iack_cycle_i,
    input wire logic [2:0] function_code_lines_i,
    input wire logic [3:0] addr_hi_i,
    input wire logic [2:0] addr_lvl_i,
    output logic [7:0] vector_o,
    output logic vector_valid_o,
    output logic external_vector_o,
    // Dedicated acknowledge pins, active high
    output logic dedicated_ack_level7_o,
    output logic dedicated_ack_level6_o,
    output logic dedicated_ack_level1_o
);
    localparam int EVT_BITS = NUM_SRC * EV_W;

    // Bus and register state
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic [15:0] mode_r;
    logic [NUM_SRC-1:0] mask_r;
    logic [EVT_BITS-1:0] even_r;
    logic [1:0] ctrl_r;
    logic wr_pend_nxt;
    logic [7:0] wr_addr_nxt;
    logic [31:0] rdata_nxt;
    logic [15:0] mode_nxt;
    logic [NUM_SRC-1:0] mask_nxt;
    logic [EVT_BITS-1:0] even_nxt;
    logic [1:0] ctrl_nxt;
    logic [NUM_SRC-1:0] sw_clr;

    // Acknowledge and core state
    logic iack_prev_r;
    logic [7:0] vector_r;
    logic vector_valid_r;
    logic ext_vec_r;
    logic [2:0] ack_r;
    logic [2:0] core_level_r;
    logic int_ind_r;
    logic bus_clear_request_r;
    logic iack_prev_nxt;
    logic [7:0] vector_nxt;
    logic vector_valid_nxt;
    logic ext_vec_nxt;
    logic [2:0] ack_nxt;
    logic [2:0] core_level_nxt;
    logic int_ind_nxt;
    logic bus_clear_request_nxt;
    logic [NUM_SRC-1:0] ack_clr;
    logic [2:0] ded_clr;

    // Combinational status
    logic [NUM_SRC-1:0] pend_w;
    logic [NUM_SRC-1:0] int_req;
    logic int_any;
    logic [NUM_SRC-1:0] int_sel;
    logic [4:0] int_code;
    logic [2:0] pins_n;
    logic [2:0] ded_req;
    logic [2:0] ext_level;
    logic dedicated;
    logic iack_hit;
    logic iack_start;

    assign dedicated = mode_r[lpic_pkg::MODE_DED_BIT]; // [R20]

    // Per-source pending latches and request pin detectors
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            source_collect #(.EV_W(EV_W)) u_src (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .events_i(src_events_i[g*EV_W +: EV_W]),
                .event_en_i(even_r[g*EV_W +: EV_W]), // [R2]
                .clr_i(ack_clr[g] | sw_clr[g]), // [R21]
                .pend_o(pend_w[g]) // [R1]
            );
        end
        for (g = 0; g < 3; g++) begin : g_pin
            dedicated_line u_pin (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .line_n_i(request_pins_n_i[g]),
                .edge_mode_i(dedicated & mode_r[lpic_pkg::MODE_ET1_BIT + g]), // [R7]
                .ack_clr_i(ded_clr[g]),
                .line_n_o(pins_n[g]),
                .req_o(ded_req[g])
            );
        end
    endgenerate

    // Source index i ranks above i-1; its vector code is i+1
    always_comb begin
        int_req = pend_w & mask_r; // [R1]
        int_any = |int_req;
        int_sel = '0;
        int_code = lpic_pkg::CODE_ERR;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (int_req[i]) begin
                int_sel = '0;
                int_sel[i] = 1'b1; // [R18] [R19]
                int_code = 5'(i + 1);
            end
        end
    end

    // External level from pins
    always_comb begin
        if (dedicated) begin
            if (ded_req[2]) begin
                ext_level = lpic_pkg::LVL_7; // [R6]
            end else if (ded_req[1]) begin
                ext_level = lpic_pkg::LVL_6;
            end else if (ded_req[0]) begin
                ext_level = lpic_pkg::LVL_1;
            end else begin
                ext_level = 3'h0;
            end
        end else begin
            ext_level = 3'h7 - pins_n; // [R3] [R5]
            // Level 4 belongs to internal sources; ignore it from outside
            if (ext_level == lpic_pkg::LVL_INT) begin
                ext_level = 3'h0; // [R4]
            end
        end
    end

    assign iack_hit = iack_cycle_i && function_code_lines_i == lpic_pkg::FC_IACK
        && addr_hi_i == lpic_pkg::ADDR_HI_IACK; // [R13]
    assign iack_start = iack_hit & ~iack_prev_r;

    // Register bus: zero wait states, read data registered in address phase
    always_comb begin
        logic take;
        take = hsel_i & htrans_i[1] & hready_i;
        wr_pend_nxt = take & hwrite_i;
        wr_addr_nxt = take ? haddr_i[7:0] : wr_addr_r;
        rdata_nxt = rdata_r;
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        even_nxt = even_r;
        ctrl_nxt = ctrl_r;
        sw_clr = '0;
        if (take && !hwrite_i) begin
            case ({haddr_i[7:2], 2'b00})
                lpic_pkg::OFS_MODE: rdata_nxt = {16'h0000, mode_r};
                lpic_pkg::OFS_PEND: rdata_nxt = 32'(pend_w);
                lpic_pkg::OFS_MASK: rdata_nxt = 32'(mask_r);
                lpic_pkg::OFS_EVEN: rdata_nxt = 32'(even_r);
                lpic_pkg::OFS_CTRL: rdata_nxt = 32'(ctrl_r);
                lpic_pkg::OFS_STAT: rdata_nxt = {24'h000000, 2'b00, ext_level, core_level_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_pend_r) begin
            case ({wr_addr_r[7:2], 2'b00})
                lpic_pkg::OFS_MODE: mode_nxt = hwdata_i[15:0] & lpic_pkg::MODE_WMASK;
                lpic_pkg::OFS_PEND: sw_clr = hwdata_i[NUM_SRC-1:0];
                lpic_pkg::OFS_MASK: mask_nxt = hwdata_i[NUM_SRC-1:0]; // [R1]
                lpic_pkg::OFS_EVEN: even_nxt = hwdata_i[EVT_BITS-1:0]; // [R2]
                lpic_pkg::OFS_CTRL: ctrl_nxt = hwdata_i[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h00000000;
            mode_r <= lpic_pkg::MODE_RST;
            mask_r <= lpic_pkg::MASK_RST;
            even_r <= lpic_pkg::EVEN_RST;
            ctrl_r <= lpic_pkg::CTRL_RST;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
            even_r <= even_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // Acknowledge, vector and core level
    always_comb begin
        iack_prev_nxt = iack_hit;
        vector_nxt = vector_r;
        vector_valid_nxt = 1'b0;
        ext_vec_nxt = 1'b0;
        ack_clr = '0;
        ded_clr = 3'b000;
        ack_nxt = 3'b000;
        if (iack_hit && dedicated && ctrl_r[lpic_pkg::CTRL_ACK_BIT]) begin
            ack_nxt[2] = addr_lvl_i == lpic_pkg::LVL_7; // [R9]
            ack_nxt[1] = addr_lvl_i == lpic_pkg::LVL_6;
            ack_nxt[0] = addr_lvl_i == lpic_pkg::LVL_1;
        end
        if (iack_start) begin
            case (addr_lvl_i)
                lpic_pkg::LVL_INT: begin
                    // No internal request left gives the error code
                    vector_nxt = {mode_r[7:5], int_code}; // [R14] [R15] [R22]
                    vector_valid_nxt = 1'b1;
                    ack_clr = int_sel; // [R21]
                end
                lpic_pkg::LVL_7: begin
                    ded_clr[2] = 1'b1; // [R21] [R23]
                    vector_nxt = {mode_r[7:5], lpic_pkg::CODE_L7};
                    vector_valid_nxt = mode_r[lpic_pkg::MODE_IV7_BIT]; // [R16]
                    ext_vec_nxt = ~mode_r[lpic_pkg::MODE_IV7_BIT]; // [R17]
                end
                lpic_pkg::LVL_6: begin
                    ded_clr[1] = 1'b1;
                    vector_nxt = {mode_r[7:5], lpic_pkg::CODE_L6};
                    vector_valid_nxt = mode_r[lpic_pkg::MODE_IV6_BIT]; // [R16]
                    ext_vec_nxt = ~mode_r[lpic_pkg::MODE_IV6_BIT];
                end
                lpic_pkg::LVL_1: begin
                    ded_clr[0] = 1'b1;
                    vector_nxt = {mode_r[7:5], lpic_pkg::CODE_L1};
                    vector_valid_nxt = mode_r[lpic_pkg::MODE_IV1_BIT]; // [R16]
                    ext_vec_nxt = ~mode_r[lpic_pkg::MODE_IV1_BIT];
                end
                default: begin
                    ext_vec_nxt = 1'b1; // [R17]
                end
            endcase
        end
        // Highest of internal level and external level reaches the core
        if (int_any && ext_level < lpic_pkg::LVL_INT) begin
            core_level_nxt = lpic_pkg::LVL_INT; // [R10] [R11]
        end else begin
            core_level_nxt = ext_level; // [R11]
        end
        int_ind_nxt = int_any;
        bus_clear_request_nxt = int_any & ctrl_r[lpic_pkg::CTRL_BUS_CLEAR_REQUEST_BIT]; // [R12]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iack_prev_r <= 1'b0;
            vector_r <= 8'h00;
            vector_valid_r <= 1'b0;
            ext_vec_r <= 1'b0;
            ack_r <= 3'b000;
            core_level_r <= 3'h0;
            int_ind_r <= 1'b0;
            bus_clear_request_r <= 1'b0;
        end else begin
            iack_prev_r <= iack_prev_nxt;
            vector_r <= vector_nxt;
            vector_valid_r <= vector_valid_nxt;
            ext_vec_r <= ext_vec_nxt;
            ack_r <= ack_nxt;
            core_level_r <= core_level_nxt;
            int_ind_r <= int_ind_nxt;
            bus_clear_request_r <= bus_clear_request_nxt;
        end
    end

    assign hrdata_o = rdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign core_level_o = core_level_r;
    assign internal_pending_indication_o = int_ind_r;
    assign bus_clear_request_o = bus_clear_request_r;
    assign vector_o = vector_r;
    assign vector_valid_o = vector_valid_r;
    assign external_vector_o = ext_vec_r;
    assign dedicated_ack_level7_o = ack_r[2];
    assign dedicated_ack_level6_o = ack_r[1];
    assign dedicated_ack_level1_o = ack_r[0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    int_level_a: assert property ((int_any && ext_level < 3'h4) |=> core_level_o == 3'h4) // [R10]
        else $error("internal request not shown at level 4");
    ext_wins_a: assert property ((ext_level > 3'h4) |=> core_level_o == $past(ext_level)) // [R11]
        else $error("higher external level not presented");
    vec_int_a: assert property ((iack_start && addr_lvl_i == 3'h4) |=> vector_valid_o) // [R14]
        else $error("no vector for level 4 acknowledge");
    vec_high_a: assert property (vector_valid_o |-> vector_o[7:5] == $past(mode_r[7:5])) // [R15]
        else $error("vector high bits differ from mode config");
    err_code_a: assert property ((iack_start && addr_lvl_i == 3'h4 && !int_any) // [R22]
        |=> vector_o[4:0] == 5'h00)
        else $error("error code missing");
    src_code_a: assert property ((iack_start && addr_lvl_i == 3'h4 && int_any) // [R18]
        |=> vector_o[4:0] != 5'h00 ##1 (pend_w & $past(int_sel, 2)) == '0
        || $past(|src_events_i) || $past(|src_events_i, 2))
        else $error("acknowledged source not served or not cleared");
    bus_clear_request_gate_a: assert property (!ctrl_r[0] |=> !bus_clear_request_o) // [R12]
        else $error("bus clear raised while disabled");
    mask_all_a: assert property ((mask_r == '0) ##1 (mask_r == '0) // [R1]
        |-> !internal_pending_indication_o)
        else $error("masked source reached the core");
    ext_vec_a: assert property ((iack_start && addr_lvl_i == 3'h7 && !mode_r[14]) // [R16]
        |=> external_vector_o && !vector_valid_o)
        else $error("level 7 vector not left to device");
    ack_mode_a: assert property (dedicated_ack_level7_o |-> $past(dedicated)) // [R9]
        else $error("acknowledge pin outside dedicated mode");
    iack_dec_a: assert property ((iack_cycle_i && function_code_lines_i != 3'h7) // [R13]
        |=> !vector_valid_o && !external_vector_o)
        else $error("acknowledge taken with wrong function code");

    int_vec_c: cover property (iack_start && addr_lvl_i == 3'h4 && int_any);
    err_vec_c: cover property (iack_start && addr_lvl_i == 3'h4 && !int_any);
    ext_vec_c: cover property (external_vector_o);
    ded_ack_c: cover property (dedicated_ack_level6_o);
endmodule

// >>> common/lpic_pkg.sv
// Notes on behaviour
// [R1] Fifteen internal sources accepted; each one maskable on its own.
// [R2] Every event inside a source has its own enable bit.
// [R3] Normal mode: three pins form an encoded priority level, up to seven levels.
// [R4] Outside logic never presents level 4 on the encoded pins.
// [R5] Encoded pins: 000=7, 001=6, 010=5, 100=3, 101=2, 110=1.
// [R6] Dedicated mode: pins are request lines for levels 7, 6 and 1.
// [R7] Each dedicated line chooses edge or level detection independently.
// [R8] Dedicated mode: outside devices never use levels 2, 3, 5 or 4.
// [R9] Dedicated mode with ack pins enabled drives acknowledge pins for 7, 6, 1.
// [R10] All internal requests sit at fixed level 4.
// [R11] Priority encoder presents only the highest pending level to the core.
// [R12] Internal pending indication may optionally raise the bus clear request.
// [R13] Acknowledge cycle: function code 111, address 19..16 high, 3..1 the level.
// [R14] Internal requests get their vector driven on the low data byte.
// [R15] Vector is three programmed high bits joined to five source bits.
// [R16] Mode config may make the block supply vectors for external levels too.
// [R17] External device drives its own vector or asserts autovector.
// [R18] Level 4 order: input3, input2, ser1, bus err, dma, ser2 ... input0.
// [R19] General DMA source carries only the general DMA channel.
// [R20] Mode bit 0 selects encoded inputs, 1 selects dedicated lines.
// [R21] Acknowledged request is cleared and remaining requests re-evaluated.
// [R22] Level 4 acknowledge with nothing internal pending gives code 00000.
// [R23] Edge-detected dedicated request stays pending until acknowledged.
package lpic_pkg;
    localparam int NUM_SRC = 15;
    localparam int EV_W = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PEND = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_EVEN = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // Mode register fields
    localparam int MODE_DED_BIT = 15;
    localparam int MODE_IV7_BIT = 14;
    localparam int MODE_IV6_BIT = 13;
    localparam int MODE_IV1_BIT = 12;
    localparam int MODE_ET7_BIT = 10;
    localparam int MODE_ET6_BIT = 9;
    localparam int MODE_ET1_BIT = 8;
    localparam int MODE_VHI_LSB = 5;
    localparam logic [15:0] MODE_WMASK = 16'hF7E0;

    // Control register fields
    localparam int CTRL_BUS_CLEAR_REQUEST_BIT = 0;
    localparam int CTRL_ACK_BIT = 1;

    // Reset values
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [14:0] MASK_RST = 15'h0000;
    localparam logic [29:0] EVEN_RST = 30'h00000000;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Acknowledge decode and vector codes
    localparam logic [2:0] FC_IACK = 3'h7;
    localparam logic [3:0] ADDR_HI_IACK = 4'hF;
    localparam logic [2:0] LVL_INT = 3'h4;
    localparam logic [2:0] LVL_7 = 3'h7;
    localparam logic [2:0] LVL_6 = 3'h6;
    localparam logic [2:0] LVL_1 = 3'h1;
    localparam logic [4:0] CODE_ERR = 5'h00;
    localparam logic [4:0] CODE_L7 = 5'h17;
    localparam logic [4:0] CODE_L6 = 5'h16;
    localparam logic [4:0] CODE_L1 = 5'h11;
endpackage

// >>> src/source_collect.sv
`timescale 1ns/10ps
module source_collect #(
    parameter int EV_W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Events and control
    input wire logic [EV_W-1:0] events_i,
    input wire logic [EV_W-1:0] event_en_i,
    input wire logic clr_i,
    // Status
    output logic pend_o
);
    logic pend_r;
    logic pend_nxt;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        pend_nxt = (pend_r & ~clr_i) | (|(events_i & event_en_i)); // [R2]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    assign pend_o = pend_r;

    set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        (|(events_i & event_en_i)) |=> pend_o)
        else $error("enabled event not latched");
endmodule

// >>> src/dedicated_line.sv
`timescale 1ns/10ps
module dedicated_line (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin, active low, asynchronous
    input wire logic line_n_i,
    // Control
    input wire logic edge_mode_i,
    input wire logic ack_clr_i,
    // Results
    output logic line_n_o,
    output logic req_o
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic pend_r;
    logic sync1_nxt;
    logic sync2_nxt;
    logic prev_nxt;
    logic pend_nxt;
    logic fall;

    always_comb begin
        sync1_nxt = line_n_i;
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
        fall = prev_r & ~sync2_r;
        // Latched until acknowledged, even if the line goes back high
        pend_nxt = edge_mode_i & ((pend_r & ~ack_clr_i) | fall); // [R7] [R23]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r <= 1'b1;
            pend_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign line_n_o = sync2_r;
    assign req_o = edge_mode_i ? pend_r : ~sync2_r; // [R7]

    edge_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R23]
        (edge_mode_i && req_o && !ack_clr_i) ##1 edge_mode_i |-> req_o)
        else $error("edge request dropped before acknowledge");
endmodule

// >>> dv/core_model.sv
`timescale 1ns/10ps
module core_model (
    // Clock
    input wire logic clk_i,
    // Answer from the block
    input wire logic [7:0] vector_i,
    input wire logic vector_valid_i,
    input wire logic external_vector_i,
    input wire logic [2:0] ack_pins_i,
    // Acknowledge cycle and request pins
    output logic iack_o,
    output logic [2:0] fc_o,
    output logic [3:0] ahi_o,
    output logic [2:0] alvl_o,
    output logic [2:0] pins_n_o
);
    logic autovec;

    initial begin
        iack_o = 1'b0;
        fc_o = 3'h5;
        ahi_o = 4'h0;
        alvl_o = 3'h0;
        pins_n_o = 3'h7;
        autovec = 1'b0;
    end

    // Encoded level, 0 means none; the internal level is never offered
    task automatic level(input logic [2:0] l);
        @(posedge clk_i);
        if (l != 3'h4) begin
            pins_n_o <= 3'h7 - l;
        end
    endtask

    // Dedicated lines only on 7, 6 and 1
    task automatic lines(input logic [2:0] v);
        @(posedge clk_i);
        pins_n_o <= v;
    endtask

    task automatic ack(input logic [2:0] l, input logic [2:0] f, input logic [3:0] h,
                       output logic [7:0] vec, output logic vv, output logic ev,
                       output logic [2:0] akp);
        @(posedge clk_i);
        iack_o <= 1'b1;
        fc_o <= f;
        ahi_o <= h;
        alvl_o <= l;
        @(posedge clk_i);
        #1;
        vec = vector_i;
        vv = vector_valid_i;
        ev = external_vector_i;
        akp = ack_pins_i;
        // Block declined to supply: fall back to autovector
        autovec = ev;
        @(posedge clk_i);
        iack_o <= 1'b0;
        fc_o <= 3'h5;
        ahi_o <= 4'h0;
        alvl_o <= ~l;
        @(posedge clk_i);
    endtask
endmodule

// >>> dv/level_priority_interrupt_controller_tb.sv
`timescale 1ns/10ps
module level_priority_interrupt_controller_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel, hwrite, hready, hresp, iack, ind, bus_clear_request, vv, evo, ak7, ak6, ak1;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [29:0] ev;
    logic [2:0] pins_n, lvl, fc, alvl, hsize;
    logic [3:0] ahi;
    logic [7:0] vec;
    logic [2:0] lvls [6] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1};
    int mismatches = 0;
    int tests_run = 0;

    always #5 clk_i = ~clk_i;

    level_priority_interrupt_controller dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .src_events_i(ev), .request_pins_n_i(pins_n), .core_level_o(lvl),
        .internal_pending_indication_o(ind), .bus_clear_request_o(bus_clear_request),
        .iack_cycle_i(iack), .function_code_lines_i(fc), .addr_hi_i(ahi),
        .addr_lvl_i(alvl), .vector_o(vec), .vector_valid_o(vv), .external_vector_o(evo),
        .dedicated_ack_level7_o(ak7), .dedicated_ack_level6_o(ak6),
        .dedicated_ack_level1_o(ak1));

    core_model cm (.clk_i(clk_i), .vector_i(vec), .vector_valid_i(vv),
        .external_vector_i(evo), .ack_pins_i({ak7, ak6, ak1}), .iack_o(iack), .fc_o(fc),
        .ahi_o(ahi), .alvl_o(alvl), .pins_n_o(pins_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("Compares %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            mismatches++;
            print_verdict;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic wait_lvl(input logic [2:0] l);
        int n;
        n = 0;
        while (lvl !== l && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(lvl, l);
        // A lost level would stall every later step
        if (lvl !== l) begin
            print_verdict;
        end
    endtask

    task automatic fire(input logic [29:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 30'h0;
    endtask

    task automatic ack_chk(input logic [2:0] l, input logic [7:0] vexp, input logic ie,
                           input logic [2:0] kexp);
        logic [7:0] v;
        logic a, b;
        logic [2:0] k;
        cm.ack(l, 3'h7, 4'hF, v, a, b, k);
        chk({a, b, k}, {ie, ~ie, kexp});
        if (ie) begin
            chk(v, vexp);
        end
    endtask

    task automatic t_reset;
        logic [31:0] r;
        chk({lvl, ind, bus_clear_request, vv, evo, ak7, ak6, ak1, hresp}, 32'h0);
        bus(1'b0, lpic_pkg::OFS_MODE, 32'h0, r);
        chk(r, 32'h0);
        bus(1'b0, 8'h18, 32'h0, r);
        chk(r, 32'h0);
    endtask

    task automatic t_internal;
        logic [31:0] r;
        wr(lpic_pkg::OFS_MODE, 32'hA0);
        wr(lpic_pkg::OFS_MASK, 32'h7FFE);
        wr(lpic_pkg::OFS_EVEN, 32'h15555555);
        wr(lpic_pkg::OFS_CTRL, 32'h1);
        // Disabled event of one source must not latch
        fire(30'h800);
        repeat (3) @(posedge clk_i);
        bus(1'b0, lpic_pkg::OFS_PEND, 32'h0, r);
        chk(r, 32'h0);
        fire(30'h10100001);
        wait_lvl(3'h4);
        chk({ind, bus_clear_request}, 32'h3);
        ack_chk(3'h4, 8'hAF, 1'b1, 3'h0);
        ack_chk(3'h4, 8'hAB, 1'b1, 3'h0);
        ack_chk(3'h4, 8'hA0, 1'b1, 3'h0);
        bus(1'b0, lpic_pkg::OFS_PEND, 32'h0, r);
        chk(r, 32'h1);
        chk(lvl, 32'h0);
    endtask

    task automatic t_normal;
        foreach (lvls[i]) begin
            cm.level(lvls[i]);
            wait_lvl(lvls[i]);
        end
        fire(30'h4000000);
        wait_lvl(3'h4);
        cm.level(3'h6);
        wait_lvl(3'h6);
        ack_chk(3'h6, 8'h0, 1'b0, 3'h0);
        cm.level(3'h0);
        wait_lvl(3'h4);
        ack_chk(3'h4, 8'hAE, 1'b1, 3'h0);
        wait_lvl(3'h0);
    endtask

    task automatic t_dedicated;
        wr(lpic_pkg::OFS_MODE, 32'hC1A0);
        wr(lpic_pkg::OFS_CTRL, 32'h2);
        // Short low pulse on the edge-mode line, released before the check
        cm.lines(3'b110);
        repeat (4) @(posedge clk_i);
        cm.lines(3'b111);
        repeat (6) @(posedge clk_i);
        wait_lvl(3'h1);
        cm.lines(3'b011);
        wait_lvl(3'h7);
        ack_chk(3'h7, 8'hB7, 1'b1, 3'b100);
        cm.lines(3'b111);
        wait_lvl(3'h1);
        ack_chk(3'h1, 8'h0, 1'b0, 3'b001);
        wait_lvl(3'h0);
    endtask

    // Cycles that miss the decode must get no vector and no ack pin
    task automatic t_decode;
        logic [7:0] v;
        logic a, b;
        logic [2:0] k;
        cm.ack(3'h4, 3'h6, 4'hF, v, a, b, k);
        chk({a, b, k}, 32'h0);
        cm.ack(3'h7, 3'h7, 4'hE, v, a, b, k);
        chk({a, b, k}, 32'h0);
    endtask

    initial begin
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        ev = 30'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_internal;
        t_normal;
        t_dedicated;
        t_decode;
        print_verdict;
    end
endmodule
